// ### hw/pwm_stage.sv
/*
 * pwm reference generation, single pulse, fast enable and
 * complementary outputs with deadtime, behind an avalon-mm slave.
 * assumes a 20 MHz clock, a synchronous reset and a trigger pin
 * from outside the clock domain.
 */
// Notes on behaviour
// - edge mode counts up when down flag low, down when high
// - pwm mode 1 up: reference high while counter below compare
// - compare above reload holds one, compare zero holds zero except counting down in edge mode
// - pwm mode 1 edge down: low while counter above compare, else high
// - any nonzero center select gives center counting, same waves
// - center flag on down for 01, up for 10, both for 11
// - in center mode hardware owns the down flag
// - single pulse enable stops the counter at next update
// - trigger edge sets the counter run bit in single pulse
// - delay equals compare, pulse equals reload minus compare plus one
// - fast enable forces post-match level on trigger in pwm modes
// - main and complement outputs each have a polarity bit
// - enables and master enable gate outputs; idle uses deadtime
// - deadtime only with both enables and master enable set, or with master enable clear
// - main output is reference with rising edge delayed
// - complement is inverse reference with rising edge delayed
// - pulse shorter than deadtime is suppressed
// - one deadtime setting serves all channels
// - single enabled output gets reference without deadtime
// - only complement enabled: it follows reference uninverted
// - both enabled: main active on high, complement on low
// - mode 110 is pwm mode 1, 111 pwm mode 2, per channel
`timescale 1ns/10ps
module pwm_stage (
	input  wire logic        clk,               // timer clock
	input  wire logic        rst,               // sync reset
	input  wire logic [5:0]  avs_address,       // byte address
	input  wire logic        avs_read,          // read request
	input  wire logic        avs_write,         // write request
	input  wire logic [31:0] avs_writedata,     // write data
	output logic      [31:0] avs_readdata,      // read data
	output logic             avs_waitrequest,   // stall
	input  wire logic        trigger_input,     // start trigger pin
	output logic [pwm_pkg::NUM_CH-1:0] main_output,   // main pins
	output logic [pwm_pkg::NUM_CH-1:0] complement_output, // comp pins
	output logic [pwm_pkg::NUM_CH-1:0] main_oe,     // main drive en
	output logic [pwm_pkg::NUM_CH-1:0] complement_oe, // comp drive en
	output logic             update_event       // update pulse
);
	localparam int N = pwm_pkg::NUM_CH;
	localparam int W = pwm_pkg::CNT_W;

	logic                     ack_reg;
	logic                     req;
	logic                     wr;
	logic [31:0]              rd_mux;
	pwm_pkg::ctrl_s           ctrl_reg;
	logic                     run_reg;
	logic                     dir_reg;
	logic [W-1:0]             cnt_reg;
	logic [W-1:0]             reload_reg;
	logic [W-1:0]             reload_sh;
	logic [W-1:0]             reload_act;
	logic [W-1:0]             cmp_reg [N];
	logic [W-1:0]             cmp_sh [N];
	pwm_pkg::ch_cfg_s         ch_cfg_reg [N];
	pwm_pkg::out_cfg_s        out_cfg_reg [N];
	logic                     moe_reg;
	logic                     run_off_reg;
	logic                     idle_off_reg;
	logic [N-1:0]             main_idle_reg;
	logic [N-1:0]             comp_idle_reg;
	logic [pwm_pkg::DT_W-1:0] dead_reg;
	logic [N-1:0]             flag_reg;
	logic                     upd_flag_reg;
	logic [N-1:0]             flag_set;
	logic [2:0]               trig_sync_reg;
	logic                     trig_edge;
	logic                     force_upd;
	logic                     roll;
	logic                     upd;
	logic                     at_top;
	logic                     at_bot;
	logic                     center;

	// avalon slave: one wait cycle, then the request completes
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_reg;
	assign wr              = avs_write & ack_reg;

	always_ff @(posedge clk) begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// read data caught in the wait cycle, stands at the ack edge
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address)
			pwm_pkg::ADDR_CTRL: begin
				rd_mux[pwm_pkg::CTRL_RUN]  = run_reg;
				rd_mux[pwm_pkg::CTRL_DOWN] = dir_reg;
				rd_mux[pwm_pkg::CTRL_CFG_MSB:pwm_pkg::CTRL_CFG_LSB] =
					ctrl_reg;
			end
			pwm_pkg::ADDR_RELOAD: rd_mux[W-1:0] = reload_reg;
			pwm_pkg::ADDR_CHMODE: begin
				for (int k = 0; k < N; k++)
					rd_mux[k*pwm_pkg::CH_CFG_W +: pwm_pkg::CH_CFG_W] =
						ch_cfg_reg[k];
			end
			pwm_pkg::ADDR_OUTCFG: begin
				for (int k = 0; k < N; k++)
					rd_mux[k*pwm_pkg::OUT_CFG_W +: pwm_pkg::OUT_CFG_W] =
						out_cfg_reg[k];
				rd_mux[pwm_pkg::OUT_MOE]      = moe_reg;
				rd_mux[pwm_pkg::OUT_RUN_OFF]  = run_off_reg;
				rd_mux[pwm_pkg::OUT_IDLE_OFF] = idle_off_reg;
				rd_mux[pwm_pkg::OUT_MIDLE_LSB +: N] = main_idle_reg;
				rd_mux[pwm_pkg::OUT_CIDLE_LSB +: N] = comp_idle_reg;
			end
			pwm_pkg::ADDR_DEAD: rd_mux[pwm_pkg::DT_W-1:0] = dead_reg;
			pwm_pkg::ADDR_STATUS: begin
				rd_mux[N-1:0]                 = flag_reg;
				rd_mux[pwm_pkg::STAT_UPD_BIT] = upd_flag_reg;
			end
			pwm_pkg::ADDR_COUNT: rd_mux[W-1:0] = cnt_reg;
			default: begin
				for (int k = 0; k < N; k++)
					if (avs_address == pwm_pkg::cmp_addr(k))
						rd_mux[W-1:0] = cmp_reg[k];
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack_reg)
			avs_readdata <= rd_mux;
	end

	// configuration registers; unmapped writes are dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg      <= '0;
			reload_reg    <= pwm_pkg::RELOAD_RST;
			moe_reg       <= 1'b0;
			run_off_reg   <= 1'b0;
			idle_off_reg  <= 1'b0;
			main_idle_reg <= '0;
			comp_idle_reg <= '0;
			dead_reg      <= '0;
			for (int k = 0; k < N; k++) begin
				cmp_reg[k]     <= pwm_pkg::CNT_ZERO;
				ch_cfg_reg[k]  <= '0;
				out_cfg_reg[k] <= '0;
			end
		end else if (wr) begin
			case (avs_address)
				pwm_pkg::ADDR_CTRL: ctrl_reg <= pwm_pkg::ctrl_s'(
					avs_writedata[pwm_pkg::CTRL_CFG_MSB:
					pwm_pkg::CTRL_CFG_LSB]);
				pwm_pkg::ADDR_RELOAD: reload_reg <= avs_writedata[W-1:0];
				pwm_pkg::ADDR_CHMODE: begin
					for (int k = 0; k < N; k++)
						ch_cfg_reg[k] <= pwm_pkg::ch_cfg_s'(avs_writedata[
							k*pwm_pkg::CH_CFG_W +: pwm_pkg::CH_CFG_W]);
				end
				pwm_pkg::ADDR_OUTCFG: begin
					for (int k = 0; k < N; k++)
						out_cfg_reg[k] <= pwm_pkg::out_cfg_s'(avs_writedata[
							k*pwm_pkg::OUT_CFG_W +: pwm_pkg::OUT_CFG_W]);
					moe_reg       <= avs_writedata[pwm_pkg::OUT_MOE];
					run_off_reg   <= avs_writedata[pwm_pkg::OUT_RUN_OFF];
					idle_off_reg  <= avs_writedata[pwm_pkg::OUT_IDLE_OFF];
					main_idle_reg <= avs_writedata[pwm_pkg::OUT_MIDLE_LSB +: N];
					comp_idle_reg <= avs_writedata[pwm_pkg::OUT_CIDLE_LSB +: N];
				end
				pwm_pkg::ADDR_DEAD:
					dead_reg <= avs_writedata[pwm_pkg::DT_W-1:0];
				default: begin
					for (int k = 0; k < N; k++)
						if (avs_address == pwm_pkg::cmp_addr(k))
							cmp_reg[k] <= avs_writedata[W-1:0];
				end
			endcase
		end
	end

	// trigger pin: two stages before anything looks at it
	always_ff @(posedge clk) begin
		if (rst)
			trig_sync_reg <= 3'h0;
		else
			trig_sync_reg <= {trig_sync_reg[1:0], trigger_input};
	end

	assign trig_edge = ctrl_reg.trig_start_enable &&
		(ctrl_reg.trig_fall ? (trig_sync_reg[2] & ~trig_sync_reg[1])
		                    : (trig_sync_reg[1] & ~trig_sync_reg[2]));

	// counter ends and update event
	assign center = ctrl_reg.center_mode_select
		!= pwm_pkg::CMS_EDGE;
	assign at_top = cnt_reg == reload_act;
	assign at_bot = cnt_reg == pwm_pkg::CNT_ZERO;
	assign roll   = run_reg & ((~dir_reg & at_top) | (dir_reg & at_bot));
	assign force_upd = wr && avs_address == pwm_pkg::ADDR_CTRL &&
		avs_writedata[pwm_pkg::CTRL_FORCE];
	assign upd          = roll | force_upd;
	assign update_event = upd;

	// run bit: software, trigger start, single pulse stop
	always_ff @(posedge clk) begin
		if (rst)
			run_reg <= 1'b0;
		else if (wr && avs_address == pwm_pkg::ADDR_CTRL)
			run_reg <= avs_writedata[pwm_pkg::CTRL_RUN];
		else if (trig_edge)
			run_reg <= 1'b1;
		else if (roll && ctrl_reg.single_pulse_enable)
			run_reg <= 1'b0;
	end

	// counter and direction; a count write wins over counting
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= pwm_pkg::CNT_ZERO;
			dir_reg <= 1'b0;
		end else begin
			if (wr && avs_address == pwm_pkg::ADDR_COUNT)
				cnt_reg <= avs_writedata[W-1:0];
			else if (force_upd)
				cnt_reg <= dir_reg && !center ? reload_act
				                              : pwm_pkg::CNT_ZERO;
			else if (run_reg && !center) begin
				if (!dir_reg)
					cnt_reg <= at_top ? pwm_pkg::CNT_ZERO
					                  : cnt_reg + pwm_pkg::CNT_ONE;
				else
					cnt_reg <= at_bot ? reload_act
					                  : cnt_reg - pwm_pkg::CNT_ONE;
			end else if (run_reg) begin
				// center: turn round at either end
				if (!dir_reg)
					cnt_reg <= at_top ? cnt_reg - pwm_pkg::CNT_ONE
					                  : cnt_reg + pwm_pkg::CNT_ONE;
				else
					cnt_reg <= at_bot ? cnt_reg + pwm_pkg::CNT_ONE
					                  : cnt_reg - pwm_pkg::CNT_ONE;
			end
			// software may steer direction only in edge mode
			if (center) begin
				if (run_reg && !dir_reg && at_top)
					dir_reg <= 1'b1;
				else if (run_reg && dir_reg && at_bot)
					dir_reg <= 1'b0;
			end else if (wr && avs_address == pwm_pkg::ADDR_CTRL)
				dir_reg <= avs_writedata[pwm_pkg::CTRL_DOWN];
		end
	end

	// reload shadow: loaded only at the update event
	always_ff @(posedge clk) begin
		if (rst)
			reload_sh <= pwm_pkg::RELOAD_RST;
		else if (upd)
			reload_sh <= reload_reg;
	end

	assign reload_act = ctrl_reg.reload_preload_enable ? reload_sh
	                                                   : reload_reg;

	// sticky status flags, write one to clear, set beats clear
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_reg     <= '0;
			upd_flag_reg <= 1'b0;
		end else begin
			if (wr && avs_address == pwm_pkg::ADDR_STATUS) begin
				flag_reg     <= flag_set | (flag_reg & ~avs_writedata[N-1:0]);
				upd_flag_reg <= upd | (upd_flag_reg &
					~avs_writedata[pwm_pkg::STAT_UPD_BIT]);
			end else begin
				flag_reg     <= flag_set | flag_reg;
				upd_flag_reg <= upd | upd_flag_reg;
			end
		end
	end

	// per-channel reference, flag and output stage
	for (genvar i = 0; i < N; i++) begin : g_ch
		logic [W-1:0] cmp_act;
		logic         match;
		logic         pwm1;
		logic         post;
		logic         is_pwm;
		logic         ref_reg;
		logic         fast_reg;
		logic         both_on;
		logic         want_m;
		logic         want_c;
		logic         use_dead;
		logic [2:0]   mode;
		pwm_pkg::out_cfg_s oc;

		assign mode = ch_cfg_reg[i].compare_output_mode;
		assign oc   = out_cfg_reg[i];

		// compare shadow loaded at each update event; bypassed when preload is off
		always_ff @(posedge clk) begin
			if (rst)
				cmp_sh[i] <= pwm_pkg::CNT_ZERO;
			else if (upd)
				cmp_sh[i] <= cmp_reg[i];
		end

		assign cmp_act = ch_cfg_reg[i].compare_preload_enable ?
			cmp_sh[i] : cmp_reg[i];
		assign match = run_reg && cnt_reg == cmp_act;

		// edge down uses <=, otherwise < (covers held 0 and 1 cases)
		assign pwm1 = (dir_reg && !center) ? cnt_reg <= cmp_act
		                                   : cnt_reg < cmp_act;
		assign is_pwm = mode == pwm_pkg::MODE_PWM1 ||
		                mode == pwm_pkg::MODE_PWM2;
		// level a match would have produced
		assign post = (mode == pwm_pkg::MODE_PWM2) ^ dir_reg;

		// center flags per direction setting
		always_comb begin
			case (ctrl_reg.center_mode_select)
				pwm_pkg::CMS_DOWN: flag_set[i] = match & dir_reg;
				pwm_pkg::CMS_UP:   flag_set[i] = match & ~dir_reg;
				default:           flag_set[i] = match;
			endcase
		end

		// fast enable holds the post-match level until match or update
		always_ff @(posedge clk) begin
			if (rst)
				fast_reg <= 1'b0;
			else if (trig_edge && is_pwm &&
			         ch_cfg_reg[i].fast_output_enable)
				fast_reg <= 1'b1;
			else if (match || upd)
				fast_reg <= 1'b0;
		end

		always_ff @(posedge clk) begin
			if (rst)
				ref_reg <= 1'b0;
			else if (is_pwm && (fast_reg || (trig_edge &&
			         ch_cfg_reg[i].fast_output_enable)))
				ref_reg <= post;
			else begin
				case (mode)
					pwm_pkg::MODE_SET:  ref_reg <= ref_reg | match;
					pwm_pkg::MODE_CLR:  ref_reg <= ref_reg & ~match;
					pwm_pkg::MODE_TOG:  ref_reg <= ref_reg ^ match;
					pwm_pkg::MODE_LOW:  ref_reg <= 1'b0;
					pwm_pkg::MODE_HIGH: ref_reg <= 1'b1;
					pwm_pkg::MODE_PWM1: ref_reg <= pwm1;
					pwm_pkg::MODE_PWM2: ref_reg <= ~pwm1;
					default:            ref_reg <= ref_reg;
				endcase
			end
		end

		// output routing by enables and master enable
		assign both_on = oc.main_output_enable &
			oc.complement_output_enable & moe_reg;
		always_comb begin
			if (!moe_reg) begin
				// idle levels reached through the deadtime
				want_m   = main_idle_reg[i] ^ oc.main_polarity;
				want_c   = comp_idle_reg[i] ^ oc.complement_polarity;
				use_dead = 1'b1;
			end else if (both_on) begin
				want_m   = ref_reg;
				want_c   = ~ref_reg;
				use_dead = 1'b1;
			end else begin
				// single enable bypasses the deadtime
				want_m   = oc.main_output_enable & ref_reg;
				want_c   = oc.complement_output_enable & ref_reg;
				use_dead = 1'b0;
			end
		end

		deadtime_pair u_dead (
			.clk       (clk),
			.rst       (rst),
			.want_main (want_m),
			.want_comp (want_c),
			.use_dead  (use_dead),
			.dead      (dead_reg),
			.main_pol  (oc.main_polarity),
			.comp_pol  (oc.complement_polarity),
			.main_lvl  (main_output[i]),
			.comp_lvl  (complement_output[i])
		);
	end

	// drive enables: off-state bits keep pins driven when disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			main_oe       <= '0;
			complement_oe <= '0;
		end else begin
			for (int k = 0; k < N; k++) begin
				main_oe[k] <= moe_reg ?
					(out_cfg_reg[k].main_output_enable | run_off_reg)
					: idle_off_reg;
				complement_oe[k] <= moe_reg ?
					(out_cfg_reg[k].complement_output_enable | run_off_reg)
					: idle_off_reg;
			end
		end
	end

endmodule // pwm_stage

// ### hw/pwm_pkg.sv
/*
 * shared constants and carrier types of the pwm output stage:
 * register map, field positions, mode codes and config structs.
 * assumes a 32-bit avalon-mm slave with byte addresses.
 */
package pwm_pkg;

	localparam int NUM_CH = 3;
	localparam int CNT_W  = 16;
	localparam int DT_W   = 8;

	// register byte addresses
	localparam logic [5:0] ADDR_CTRL   = 6'h00;
	localparam logic [5:0] ADDR_RELOAD = 6'h04;
	localparam logic [5:0] ADDR_CMP0   = 6'h08;
	localparam logic [5:0] ADDR_CHMODE = 6'h14;
	localparam logic [5:0] ADDR_OUTCFG = 6'h18;
	localparam logic [5:0] ADDR_DEAD   = 6'h1C;
	localparam logic [5:0] ADDR_STATUS = 6'h20;
	localparam logic [5:0] ADDR_COUNT  = 6'h24;

	// control register fields
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_DOWN    = 1;
	localparam int CTRL_CFG_LSB = 2;
	localparam int CTRL_CFG_MSB = 7;
	localparam int CTRL_FORCE   = 8;

	// output config register fields
	localparam int OUT_CFG_W     = 4;
	localparam int OUT_MOE       = 12;
	localparam int OUT_RUN_OFF   = 13;
	localparam int OUT_IDLE_OFF  = 14;
	localparam int OUT_MIDLE_LSB = 16;
	localparam int OUT_CIDLE_LSB = 20;

	// per-channel mode field width and status fields
	localparam int CH_CFG_W     = 5;
	localparam int STAT_UPD_BIT = 4;

	// compare output mode codes
	localparam logic [2:0] MODE_FROZEN = 3'h0;
	localparam logic [2:0] MODE_SET    = 3'h1;
	localparam logic [2:0] MODE_CLR    = 3'h2;
	localparam logic [2:0] MODE_TOG    = 3'h3;
	localparam logic [2:0] MODE_LOW    = 3'h4;
	localparam logic [2:0] MODE_HIGH   = 3'h5;
	localparam logic [2:0] MODE_PWM1   = 3'h6;
	localparam logic [2:0] MODE_PWM2   = 3'h7;

	// center mode select codes
	localparam logic [1:0] CMS_EDGE = 2'h0;
	localparam logic [1:0] CMS_DOWN = 2'h1;
	localparam logic [1:0] CMS_UP   = 2'h2;
	localparam logic [1:0] CMS_BOTH = 2'h3;

	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
	localparam logic [CNT_W-1:0] RELOAD_RST = 16'hFFFF;
	localparam logic [DT_W-1:0]  DT_MAX   = 8'hFF;

	typedef struct packed {
		logic       trig_fall;
		logic       trig_start_enable;
		logic       reload_preload_enable;
		logic       single_pulse_enable;
		logic [1:0] center_mode_select;
	} ctrl_s;

	typedef struct packed {
		logic       compare_preload_enable;
		logic       fast_output_enable;
		logic [2:0] compare_output_mode;
	} ch_cfg_s;

	typedef struct packed {
		logic complement_polarity;
		logic complement_output_enable;
		logic main_polarity;
		logic main_output_enable;
	} out_cfg_s;

	function automatic logic [5:0] cmp_addr(input int k);
		return ADDR_CMP0 + 6'(k * 4);
	endfunction

endpackage

// ### hw/deadtime_pair.sv
/*
 * deadtime generator for one channel: delays every rising edge
 * of the two active requests by the deadtime, applies polarity.
 * assumes want inputs come from registers on the same clock.
 */
`timescale 1ns/10ps
module deadtime_pair (
	input  wire logic                   clk,       // timer clock
	input  wire logic                   rst,       // sync reset
	input  wire logic                   want_main, // main active request
	input  wire logic                   want_comp, // comp active request
	input  wire logic                   use_dead,  // insert deadtime
	input  wire logic [pwm_pkg::DT_W-1:0] dead,    // deadtime in cycles
	input  wire logic                   main_pol,  // main active low
	input  wire logic                   comp_pol,  // comp active low
	output logic                        main_lvl,  // main pin level
	output logic                        comp_lvl   // comp pin level
);
	logic [1:0]               prev_reg;
	logic [pwm_pkg::DT_W-1:0] held_reg;
	logic                     chg;
	logic                     ok;

	// any change of the request pair restarts the deadtime
	assign chg = {want_main, want_comp} != prev_reg;
	assign ok  = !use_dead || dead == '0 ||
	             (!chg && held_reg >= dead);

	// cycles since the last change, saturating
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_reg <= 2'h0;
			held_reg <= '0;
		end else begin
			prev_reg <= {want_main, want_comp};
			if (chg)
				held_reg <= 8'h01;
			else if (held_reg != pwm_pkg::DT_MAX)
				held_reg <= held_reg + 8'h01;
		end
	end

	// falling edges pass at once, rising ones wait for ok
	always_ff @(posedge clk) begin
		if (rst) begin
			main_lvl <= 1'b0;
			comp_lvl <= 1'b0;
		end else begin
			main_lvl <= main_pol ^ (want_main & ok);
			comp_lvl <= comp_pol ^ (want_comp & ok);
		end
	end

endmodule // deadtime_pair

// ### tb/pwm_stage_assertions.sv
/* checker for the pwm stage ports; snoops bus writes of OUTCFG.
   assumes it is bound to pwm_stage. */
`timescale 1ns/10ps
module pwm_stage_chk (
	input wire logic        clk,               // timer clock
	input wire logic        rst,               // sync reset
	input wire logic [5:0]  avs_address,       // byte address
	input wire logic        avs_read,          // read request
	input wire logic        avs_write,         // write request
	input wire logic [31:0] avs_writedata,     // write data
	input wire logic        avs_waitrequest,   // stall
	input wire logic [2:0]  main_output,       // main pins
	input wire logic [2:0]  complement_output, // comp pins
	input wire logic [2:0]  main_oe,           // main drive en
	input wire logic [2:0]  complement_oe,     // comp drive en
	input wire logic        update_event       // update pulse
);
	logic [14:0] oc_reg;
	logic [1:0]  age_reg;
	logic        set_w;

	// shadow of the output config; pins lag it by one edge, checks wait three
	assign set_w = age_reg == 2'h3;
	always_ff @(posedge clk) begin
		if (rst) begin
			oc_reg  <= 15'h0000;
			age_reg <= 2'h0;
		end else if (avs_write && !avs_waitrequest &&
			avs_address == pwm_pkg::ADDR_OUTCFG) begin
			oc_reg  <= avs_writedata[14:0];
			age_reg <= 2'h0;
		end else if (!set_w) begin
			age_reg <= age_reg + 2'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	wait_first_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest) else $error("no wait state");
	wait_done_a: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
	bus_idle_a: assert property (!(avs_read | avs_write) |-> !avs_waitrequest) else $error("idle stall");
	no_overlap_a: assert property (set_w && oc_reg[12] && oc_reg[3:0] == 4'h5 |-> !(main_output[0] && complement_output[0])) else $error("both active");
	main_only_a: assert property (set_w && oc_reg[12] && oc_reg[3:0] == 4'h1 |-> !complement_output[0]) else $error("comp not idle");
	comp_only_a: assert property (set_w && oc_reg[12] && oc_reg[11:8] == 4'h4 |-> !main_output[2]) else $error("main not idle");
	oe_on_a: assert property (set_w && oc_reg[12] |-> main_oe[0] == (oc_reg[0] | oc_reg[13]) && complement_oe[0] == (oc_reg[2] | oc_reg[13])) else $error("enable wrong");
	oe_off_a: assert property (set_w && !oc_reg[12] |-> main_oe == {3{oc_reg[14]}}) else $error("idle enable wrong");
	reset_out_a: assert property (disable iff (1'b0) rst |=> main_oe == 3'h0 && complement_oe == 3'h0 && main_output == 3'h0) else $error("reset pins");

	cover property (update_event);
	cover property ($rose(main_output[0]));
	cover property ($rose(complement_output[0]));
endmodule // pwm_stage_chk
bind pwm_stage pwm_stage_chk u_chk (.clk, .rst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_waitrequest, .main_output,
	.complement_output, .main_oe, .complement_oe, .update_event);

// ### tb/switch_model.sv
/* half-bridge drivers behind the pins: counts shoot-through.
   assumes active-high pins; undriven gate inputs are pulled down. */
`timescale 1ns/10ps
module switch_model (
	input wire logic       clk,    // timer clock
	input wire logic [2:0] hi_pin, // high-side gate pins
	input wire logic [2:0] lo_pin, // low-side gate pins
	input wire logic [2:0] hi_oe,  // high-side driven
	input wire logic [2:0] lo_oe,  // low-side driven
	output int             shoot_cnt // cycles with a leg shorted
);
	// released gates fall to the pull-down, so they switch off
	initial begin
		shoot_cnt = 0;
		forever @(negedge clk)
			if (|(hi_pin & hi_oe & lo_pin & lo_oe))
				shoot_cnt++;
	end
endmodule // switch_model

// ### tb/pwm_stage_tb.sv
/* self-checking bench for pwm_stage: bus tasks, pin high counts.
   assumes the checker and the switch model are compiled first. */
`timescale 1ns/10ps
module pwm_stage_tb;
	logic        clk, rst, avs_read, avs_write, trigger_input, update_event;
	logic [5:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_word;
	logic        avs_waitrequest, rd_dir;
	logic [2:0]  main_output, complement_output, main_oe, complement_oe;
	int          err_count, compares, cycles, shoot_cnt, upd;
	int          hi_m[3], hi_c[3], pulse[4];

	pwm_stage u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .trigger_input,
		.main_output, .complement_output, .main_oe, .complement_oe,
		.update_event);
	switch_model u_sw (.clk, .hi_pin(main_output), .lo_pin(complement_output),
		.hi_oe(main_oe), .lo_oe(complement_oe), .shoot_cnt);

	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			wrap_up;
		end
	end

	task wrap_up;
		$display("%0d compares, %0d mismatches", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// one avalon transfer; held until waitrequest is seen low
	task bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd_word = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	// count high pin cycles; settle first since pins lag config
	task measure(input int n);
		hi_m = '{0, 0, 0};
		hi_c = '{0, 0, 0};
		upd = 0;
		repeat (4) @(posedge clk);
		repeat (n) begin
			@(negedge clk);
			upd += int'(update_event);
			for (int k = 0; k < 3; k++) begin
				hi_m[k] += main_output[k];
				hi_c[k] += complement_output[k];
			end
		end
		@(posedge clk);
	endtask

	task exp6(input int n, input int e[6]);
		measure(n);
		for (int k = 0; k < 3; k++) begin
			chk(32'(hi_m[k]), 32'(e[k]));
			chk(32'(hi_c[k]), 32'(e[k+3]));
		end
	endtask

	initial begin
		{rst, avs_read, avs_write, trigger_input} = 4'h8;
		avs_address = 6'h00;
		avs_writedata = 32'h00000000;
		cycles = 0;
		err_count = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b1, pwm_pkg::ADDR_RELOAD, 32'h0);
		chk(rd_word, 32'h0000FFFF);
		bus(1'b0, 6'h3C, 32'hFFFFFFFF);
		bus(1'b1, 6'h3C, 32'h0);
		chk(rd_word, 32'h00000000);
		$display("reset test done");
		// period 9: ch0 pwm1, ch1 pwm2, ch2 pwm1 above reload
		bus(1'b0, pwm_pkg::ADDR_RELOAD, 32'h8);
		for (int k = 0; k < 3; k++)
			bus(1'b0, pwm_pkg::cmp_addr(k), k == 2 ? 32'h9 : 32'h3);
		bus(1'b0, pwm_pkg::ADDR_CHMODE, 32'h000018E6);
		bus(1'b0, pwm_pkg::ADDR_OUTCFG, 32'h00001111);
		bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h00000101);
		exp6(9, '{3, 6, 9, 0, 0, 0});
		bus(1'b0, pwm_pkg::cmp_addr(2), 32'h0);
		exp6(9, '{3, 6, 0, 0, 0, 0});
		bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h00000003);
		exp6(9, '{4, 5, 1, 0, 0, 0});
		$display("edge test done");
		for (int m = 1; m < 4; m++) begin
			bus(1'b0, pwm_pkg::ADDR_CTRL, 32'(1 + 4 * m));
			bus(1'b0, pwm_pkg::ADDR_STATUS, 32'h00000007);
			exp6(16, '{5, 11, 0, 0, 0, 0});
			// ch2 compares 0, so it only matches while counting down
			bus(1'b1, pwm_pkg::ADDR_STATUS, 32'h0);
			chk({31'h0, rd_word[2]}, 32'(m != 2));
		end
		$display("center test done");
		// stopped in center mode the direction bit ignores writes
		bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h0000000C);
		bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h0);
		rd_dir = rd_word[1];
		for (int v = 0; v < 2; v++) begin
			bus(1'b0, pwm_pkg::ADDR_CTRL, 32'(14 - 2 * v));
			bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h0);
			chk({31'h0, rd_word[1]}, {31'h0, rd_dir});
		end
		// leave center mode first so the up direction can be written
		bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h0);
		// ch0, ch1 complementary; ch2 complement only
		bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h00000001);
		bus(1'b0, pwm_pkg::cmp_addr(2), 32'h3);
		bus(1'b0, pwm_pkg::ADDR_OUTCFG, 32'h00001455);
		bus(1'b0, pwm_pkg::ADDR_DEAD, 32'h00000002);
		exp6(9, '{1, 4, 0, 4, 1, 3});
		bus(1'b0, pwm_pkg::ADDR_DEAD, 32'h00000004);
		exp6(9, '{0, 2, 0, 2, 0, 3});
		bus(1'b0, pwm_pkg::ADDR_OUTCFG, 32'h00001C55);
		exp6(9, '{0, 2, 0, 2, 0, 6});
		$display("deadtime test done");
		// single pulse on ch0 in pwm2, two compares, then fast enable
		bus(1'b0, pwm_pkg::ADDR_DEAD, 32'h0);
		bus(1'b0, pwm_pkg::ADDR_OUTCFG, 32'h00001111);
		for (int j = 0; j < 4; j++) begin
			bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h0);
			bus(1'b0, pwm_pkg::ADDR_CHMODE, 32'(j < 2 ? 7 : 15));
			bus(1'b0, pwm_pkg::cmp_addr(0), 32'(3 + 2 * (j % 2)));
			bus(1'b0, pwm_pkg::ADDR_COUNT, 32'h0);
			bus(1'b0, pwm_pkg::ADDR_CTRL, 32'h00000050);
			measure(10);
			chk(32'(hi_m[0]), 32'h0);
			trigger_input <= 1'b1;
			measure(30);
			pulse[j] = hi_m[0];
			chk(32'(upd), 32'h1);
			trigger_input <= 1'b0;
			bus(1'b1, pwm_pkg::ADDR_CTRL, 32'h0);
			chk({31'h0, rd_word[0]}, 32'h0);
		end
		chk(32'(pulse[0] - pulse[1]), 32'h2);
		chk(32'(pulse[2] - pulse[3]), 32'h0);
		chk(32'(shoot_cnt), 32'h0);
		$display("single pulse test done");
		wrap_up;
	end
endmodule // pwm_stage_tb
